// File: event4_alarm.sv
// fourth-event alarm: loop break, comparisons, hold, delay, interlock
// assumes an AHB-Lite master, process inputs synchronous to hclk
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
module event4_alarm #(
  parameter int TICK_CYCLES = event4_pkg::TICK_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [15:0] measured_value,
  input  wire logic [15:0] target_setpoint,
  input  wire logic [15:0] heat_side_output,
  input  wire logic [15:0] cool_side_output,
  input  wire logic [15:0] feedback_resistance_input,
  input  wire logic [15:0] out_low_limit,
  input  wire logic [15:0] out_high_limit,
  input  wire logic        autotuning_active,
  input  wire logic        autotune_done,
  input  wire logic [15:0] integral_time,
  input  wire logic        run_mode,
  input  wire logic        rate_limiter_on,
  input  wire logic        remote_mode,
  output logic             event_out,
  output logic             loop_break_alarm
);

  event4_pkg::state_s st;
  event4_pkg::state_s n;
  logic                tick;
  logic signed [16:0]  pv;
  logic signed [16:0]  sv;
  logic signed [16:0]  dev;
  logic signed [16:0]  adev;
  logic signed [16:0]  ref_v;
  logic signed [16:0]  range;
  logic signed [16:0]  x;
  logic signed [16:0]  t;
  logic signed [16:0]  g;
  logic [15:0]         mv;
  logic [19:0]         lb_limit;
  logic                is_high;
  logic                cmp_type;
  logic                hold_ok;
  logic                is_mv;
  logic                lb_off;
  logic                at_low;
  logic                at_high;
  logic                armed;
  logic                expect_rise;
  logic                moved;
  logic                in_db;
  logic                hold_en;
  logic                raw;
  logic                clear_cmd;
  logic                take;

  // ----------------------------------------------------------------------
  // period tick for timers
  // ----------------------------------------------------------------------
  tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  // hysteresis compare: on at threshold, off once back past threshold by gap
  function automatic logic hyst(input logic signed [16:0] xv, input logic signed [16:0] tv,
                                input logic signed [16:0] gv, input logic high, input logic prev);
    if (high) begin
      hyst = prev ? (xv > tv - gv) : (xv >= tv);
    end else begin
      hyst = prev ? (xv < tv + gv) : (xv <= tv);
    end
  endfunction

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    n         = st;
    pv        = {measured_value[15], measured_value};
    sv        = {target_setpoint[15], target_setpoint};
    dev       = pv - sv;
    adev      = dev[16] ? -dev : dev;
    ref_v     = {st.pv_ref[15], st.pv_ref};
    mv        = st.fbr_used ? feedback_resistance_input : heat_side_output;
    clear_cmd = 1'b0;
    take      = hsel && htrans[1] && hready;

    // data phase of a write
    if (st.wr_pend) begin
      case (st.waddr)
        event4_pkg::OFS_CFG: begin
          n.ev_type    = hwdata[event4_pkg::CFG_TYPE +: 4];
          n.hold_sel   = hwdata[event4_pkg::CFG_HOLD +: 2];
          n.interlock  = hwdata[event4_pkg::CFG_INTERLOCK];
          n.reverse    = hwdata[event4_pkg::CFG_REVERSE];
          n.heat_cool  = hwdata[event4_pkg::CFG_HEAT_COOL];
          n.temp_input = hwdata[event4_pkg::CFG_TEMP];
          n.fbr_used   = hwdata[event4_pkg::CFG_FBR];
          n.assigned   = hwdata[event4_pkg::CFG_ASSIGN];
        end
        event4_pkg::OFS_LB_TIME:  n.lb_time = hwdata[15:0];
        event4_pkg::OFS_DEADBAND: n.deadband = hwdata[15:0];
        event4_pkg::OFS_GAP:      n.gap = hwdata[15:0];
        event4_pkg::OFS_SPAN:     n.span = hwdata[15:0];
        event4_pkg::OFS_EV_SET:   n.ev_set = hwdata[15:0];
        event4_pkg::OFS_DELAY: begin
          n.delay = (hwdata[31:0] > 32'(event4_pkg::DELAY_MAX)) ? event4_pkg::DELAY_MAX : hwdata[12:0];
        end
        event4_pkg::OFS_CMD:      clear_cmd = hwdata[event4_pkg::CMD_CLEAR];
        default: ;
      endcase
    end

    // autotune result overrides a software write in the same cycle
    if (autotune_done) begin
      n.lb_time = integral_time[15] ? 16'hffff : {integral_time[14:0], 1'b0};
    end

    // comparison selection per event type
    x        = dev;
    t        = {st.ev_set[15], st.ev_set};
    is_high  = 1'b1;
    cmp_type = 1'b1;
    hold_ok  = 1'b1;
    is_mv    = 1'b0;
    case (st.ev_type)
      event4_pkg::EV_DEV_HIGH: x = dev;
      event4_pkg::EV_DEV_LOW: begin
        t       = -t;
        is_high = 1'b0;
      end
      event4_pkg::EV_DEV_HL, event4_pkg::EV_BAND: x = adev;
      event4_pkg::EV_PV_HIGH: x = pv;
      event4_pkg::EV_PV_LOW: begin
        x       = pv;
        is_high = 1'b0;
      end
      event4_pkg::EV_SV_HIGH: begin
        x       = sv;
        hold_ok = 1'b0;
      end
      event4_pkg::EV_SV_LOW: begin
        x       = sv;
        is_high = 1'b0;
        hold_ok = 1'b0;
      end
      event4_pkg::EV_HEAT_HIGH, event4_pkg::EV_HEAT_LOW: begin
        x       = {1'b0, mv};
        is_high = (st.ev_type == event4_pkg::EV_HEAT_HIGH);
        is_mv   = 1'b1;
      end
      event4_pkg::EV_COOL_HIGH, event4_pkg::EV_COOL_LOW: begin
        x       = {1'b0, cool_side_output};
        is_high = (st.ev_type == event4_pkg::EV_COOL_HIGH);
        is_mv   = 1'b1;
      end
      default: begin
        cmp_type = 1'b0;
        hold_ok  = 1'b0;
      end
    endcase

    // gap limited to its legal range; loop break never sees it
    g = {1'b0, st.gap};
    if (is_mv && g > event4_pkg::MV_GAP_MAX) begin
      g = event4_pkg::MV_GAP_MAX;
    end else if (!is_mv && g > {1'b0, st.span}) begin
      g = {1'b0, st.span};
    end
    n.cmp_on = cmp_type && hyst(x, t, g, is_high, st.cmp_on);

    // loop-break supervision
    lb_off = autotuning_active || !run_mode || st.heat_cool || (st.lb_time == 16'h0000) ||
             !st.assigned || (st.ev_type != event4_pkg::EV_LOOP_BREAK);
    at_low      = mv <= out_low_limit;
    at_high     = mv >= out_high_limit;
    armed       = !lb_off && (at_low || at_high);
    expect_rise = at_low ? !st.reverse : st.reverse;
    range       = st.temp_input ? event4_pkg::LB_RANGE_TEMP : 17'(st.span / event4_pkg::LB_RANGE_DIV);
    if (range == 17'sh00000) begin
      range = 17'sh00001;
    end
    moved    = expect_rise ? (pv > ref_v + range) : (pv < ref_v - range);
    in_db    = (st.deadband != 16'h0000) && (adev <= {1'b0, st.deadband});
    lb_limit = 20'(st.lb_time) * event4_pkg::TICKS_PER_SEC;
    if (!armed) begin
      n.lb_cnt   = '0;
      n.lb_armed = 1'b0;
      if (lb_off) begin
        n.lb_alarm = 1'b0;
      end
    end else if (!st.lb_armed || (at_low != st.lb_side_low)) begin
      n.lb_armed    = 1'b1;
      n.lb_side_low = at_low;
      n.pv_ref      = measured_value;
      n.lb_cnt      = '0;
    end else if (moved) begin
      n.pv_ref   = measured_value;
      n.lb_cnt   = '0;
      n.lb_alarm = 1'b0;
    end else if (st.lb_cnt >= lb_limit) begin
      n.lb_alarm = 1'b1;
      n.pv_ref   = measured_value;
      n.lb_cnt   = '0;
    end else if (tick) begin
      n.lb_cnt = st.lb_cnt + 20'h00001;
    end
    if (in_db) begin
      n.lb_alarm = 1'b0;
    end

    // hold: pending from reset, re-armed on stop-to-run and on setpoint change
    n.run_q = run_mode;
    n.sv_q  = target_setpoint;
    hold_en = (st.hold_sel != event4_pkg::HOLD_OFF) && hold_ok;
    if (st.hold && !n.cmp_on) begin
      n.hold = 1'b0;
    end
    if (run_mode && !st.run_q) begin
      n.hold = 1'b1;
    end
    if ((target_setpoint != st.sv_q) && (st.hold_sel == event4_pkg::HOLD_REHOLD) &&
        !rate_limiter_on && !remote_mode) begin
      n.hold = 1'b1;
    end

    // suppression, output delay, interlock latch
    raw = (st.ev_type == event4_pkg::EV_LOOP_BREAK) ? st.lb_alarm : (st.cmp_on && !(st.hold && hold_en));
    if (!raw) begin
      n.dly_cnt = '0;
      n.delayed = 1'b0;
    end else if (st.dly_cnt >= st.delay) begin
      n.delayed = 1'b1;
    end else if (tick) begin
      n.dly_cnt = st.dly_cnt + 13'h0001;
    end
    if (!st.interlock) begin
      n.latch = 1'b0;
    end else if (st.delayed) begin
      n.latch = 1'b1;
    end else if (clear_cmd) begin
      n.latch = 1'b0;
    end
    n.event_out = st.delayed || st.latch;

    // address phase; read data taken from the updated registers, status word from the current state
    n.wr_pend = take && hwrite;
    if (take) begin
      n.waddr = haddr;
    end
    if (take && !hwrite) begin
      case (haddr)
        event4_pkg::OFS_CFG: begin
          n.rdata = {20'h00000, n.assigned, n.fbr_used, n.temp_input, n.heat_cool, n.reverse,
                     n.interlock, n.hold_sel, n.ev_type};
        end
        event4_pkg::OFS_LB_TIME:  n.rdata = {16'h0000, n.lb_time};
        event4_pkg::OFS_DEADBAND: n.rdata = {16'h0000, n.deadband};
        event4_pkg::OFS_GAP:      n.rdata = {16'h0000, n.gap};
        event4_pkg::OFS_SPAN:     n.rdata = {16'h0000, n.span};
        event4_pkg::OFS_EV_SET:   n.rdata = {16'h0000, n.ev_set};
        event4_pkg::OFS_DELAY:    n.rdata = {19'h00000, n.delay};
        event4_pkg::OFS_STATUS: begin
          n.rdata = {st.lb_cnt[15:0], 9'h000, st.latch, st.delayed, st.hold, st.lb_armed, st.cmp_on,
                     st.lb_alarm, st.event_out};
        end
        default: n.rdata = 32'h00000000;
      endcase
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= event4_pkg::STATE_RESET;
    end else begin
      st <= n;
    end
  end

  // zero-wait slave, always OKAY
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign hrdata           = st.rdata;
  assign event_out        = st.event_out;
  assign loop_break_alarm = st.lb_alarm;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  lb_disable_a: assert property (@(posedge hclk) disable iff (!hresetn) lb_off |=> (!st.lb_alarm && st.lb_cnt == 20'h00000))
    else $error("loop break active while disabled");
  lb_restart_a: assert property (@(posedge hclk) disable iff (!hresetn) !armed |=> (st.lb_cnt == 20'h00000 && !st.lb_armed))
    else $error("loop break timer not restarted");
  lb_arm_a: assert property (@(posedge hclk) disable iff (!hresetn) st.lb_armed |-> $past(at_low || at_high))
    else $error("armed away from output limit");
  lb_fire_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (armed && st.lb_armed && at_low == st.lb_side_low && !moved && !in_db && st.lb_cnt >= lb_limit) |=> st.lb_alarm)
    else $error("loop break alarm not raised at time out");
  lb_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) (st.lb_alarm && in_db) |=> !st.lb_alarm)
    else $error("alarm kept inside deadband");
  at_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (autotune_done && !integral_time[15]) |=> st.lb_time == {$past(integral_time[14:0]), 1'b0})
    else $error("autotune did not load twice the integral time");
  rehold_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (target_setpoint != st.sv_q && st.hold_sel == event4_pkg::HOLD_REHOLD && !rate_limiter_on && !remote_mode) |=> st.hold)
    else $error("re-hold missed on setpoint change");
  hold_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.hold && hold_en && st.ev_type != event4_pkg::EV_LOOP_BREAK) |=> !st.delayed)
    else $error("held alarm reached the output");
  gap_free_a: assert property (@(posedge hclk) disable iff (!hresetn) (st.ev_type == event4_pkg::EV_LOOP_BREAK) |=> !st.cmp_on)
    else $error("comparison active for loop break type");
  delay_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) $rose(st.delayed) |-> $past(st.dly_cnt >= st.delay))
    else $error("event output before delay");
  latch_keep_a: assert property (@(posedge hclk) disable iff (!hresetn) (st.latch && st.interlock) |=> st.event_out)
    else $error("interlocked event dropped");

endmodule

// File: event4_pkg.sv
// constants, register map and state layout of the fourth-event alarm block
// assumes a 20 MHz hclk; values in tenths of a unit (0.1 degree, 0.1 %)
// ----------------------------------------------------------------------
// Operation
// ----------------------------------------------------------------------
// Operation
// - loop-break watch arms only with output at its low or high limit
// - armed: alarm when loop-break time ends with value inside the range
// - range fixed: 2 degrees for temperature, 0.2 % of span otherwise
// - at low limit: direct expects a rise, reverse expects a fall
// - at high limit: direct expects a fall, reverse expects a rise
// - autotune finish loads loop-break time with twice the integral time
// - no loop-break check in autotune, stop, heat/cool, time 0, unassigned
// - alarm clears on value leaving the range in time, or in deadband
// - hold select resets to off; hold after power-up and stop-to-run (power-up hold clears before any type is written; type resets to none)
// - re-hold also on setpoint change, unless limiter on or remote mode
// - a held alarm stays off while hold suppression lasts
// - interlock select is 0 unused or 1 used, reset value 0
// - gap limited to span, or to 110.0 % for output types; resets to 2
// - loop-break type ignores the differential gap
// - heat output types compare feedback resistance input when it is used
// - type code 9 selects loop break; codes 1 to 8 and 10 to 13 select comparisons
// - event output delayed 0.0 to 600.0 s, reset value zero
package event4_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int              CLK_HZ        = 20_000_000;
  localparam int              TICK_TIME_MS  = 100;
  localparam int              TICK_CYCLES   = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam logic [19:0]     TICKS_PER_SEC = 20'h0000a;
  localparam logic [12:0]     DELAY_MAX     = 13'h1770;    // 600.0 s in ticks
  localparam logic signed [16:0] MV_GAP_MAX    = 17'sh0044c; // 110.0 %
  localparam logic signed [16:0] LB_RANGE_TEMP = 17'sh00014; // 2.0 degrees
  localparam int              LB_RANGE_DIV  = 500;         // span / 500 = 0.2 %

  // ----------------------------------------------------------------------
  // event types and hold selections
  // ----------------------------------------------------------------------
  localparam logic [3:0] EV_NONE = 4'h0;
  localparam logic [3:0] EV_DEV_HIGH = 4'h1;
  localparam logic [3:0] EV_DEV_LOW = 4'h2;
  localparam logic [3:0] EV_DEV_HL = 4'h3;
  localparam logic [3:0] EV_BAND = 4'h4;
  localparam logic [3:0] EV_PV_HIGH = 4'h5;
  localparam logic [3:0] EV_PV_LOW = 4'h6;
  localparam logic [3:0] EV_SV_HIGH = 4'h7;
  localparam logic [3:0] EV_SV_LOW = 4'h8;
  localparam logic [3:0] EV_LOOP_BREAK = 4'h9;
  localparam logic [3:0] EV_HEAT_HIGH = 4'ha;
  localparam logic [3:0] EV_HEAT_LOW = 4'hb;
  localparam logic [3:0] EV_COOL_HIGH = 4'hc;
  localparam logic [3:0] EV_COOL_LOW = 4'hd;
  localparam logic [1:0] HOLD_OFF = 2'h0;
  localparam logic [1:0] HOLD_REHOLD = 2'h2;

  // ----------------------------------------------------------------------
  // register offsets and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_LB_TIME = 8'h04;
  localparam logic [7:0] OFS_DEADBAND = 8'h08;
  localparam logic [7:0] OFS_GAP = 8'h0c;
  localparam logic [7:0] OFS_SPAN = 8'h10;
  localparam logic [7:0] OFS_EV_SET = 8'h14;
  localparam logic [7:0] OFS_DELAY = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_CMD = 8'h20;
  localparam int CFG_TYPE = 0;
  localparam int CFG_HOLD = 4;
  localparam int CFG_INTERLOCK = 6;
  localparam int CFG_REVERSE = 7;
  localparam int CFG_HEAT_COOL = 8;
  localparam int CFG_TEMP = 9;
  localparam int CFG_FBR = 10;
  localparam int CFG_ASSIGN = 11;
  localparam int CMD_CLEAR = 0;
  localparam logic [15:0] GAP_RESET = 16'h0002;
  localparam logic [15:0] SPAN_RESET = 16'h0fa0;

  // ----------------------------------------------------------------------
  // state of the top module
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  waddr;
    logic [31:0] rdata;
    logic [3:0]  ev_type;
    logic [1:0]  hold_sel;
    logic        interlock;
    logic        reverse;
    logic        heat_cool;
    logic        temp_input;
    logic        fbr_used;
    logic        assigned;
    logic [15:0] lb_time;
    logic [15:0] deadband;
    logic [15:0] gap;
    logic [15:0] span;
    logic [15:0] ev_set;
    logic [12:0] delay;
    logic        hold;
    logic        cmp_on;
    logic [12:0] dly_cnt;
    logic        delayed;
    logic        latch;
    logic        event_out;
    logic [19:0] lb_cnt;
    logic        lb_armed;
    logic        lb_side_low;
    logic [15:0] pv_ref;
    logic        lb_alarm;
    logic        run_q;
    logic [15:0] sv_q;
  } state_s;

  localparam state_s STATE_RESET = '{gap: GAP_RESET, span: SPAN_RESET, assigned: 1'b1, hold: 1'b1, default: '0};

endpackage

// File: tick_gen.sv
// fixed-period tick divider for the alarm timers
// assumes one free-running clock, an asynchronous active-low reset and event4_pkg compiled first
`timescale 1ns/10ps
module tick_gen #(
  parameter int TICK_CYCLES = event4_pkg::TICK_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } tick_state_s;

  tick_state_s st;
  tick_state_s next_st;

  // count up and pulse one cycle at the end of each period
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (st.cnt == 32'(TICK_CYCLES - 1)) begin
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 32'h00000001;
    end
  end

  // period register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule

// File: process_model.sv
// behavioural model of the sensor input and heater output around the alarm
// assumes the bench sets the wanted process value and output through pv_cmd and out_cmd
`timescale 1ns/10ps
module process_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [15:0] pv_cmd,
  input  wire logic [15:0] out_cmd,
  output logic      [15:0] measured_value,
  output logic      [15:0] heat_side_output,
  output logic      [15:0] cool_side_output,
  output logic      [15:0] feedback_resistance_input
);
  // ----------------------------------------------------------------------
  // process values, updated once per clock like a sampled input
  // ----------------------------------------------------------------------
  // cool side stays off, feedback follows the heat output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      measured_value            <= 16'h0000;
      heat_side_output          <= 16'h0000;
      cool_side_output          <= 16'h0000;
      feedback_resistance_input <= 16'h0000;
    end else begin
      measured_value            <= pv_cmd;
      heat_side_output          <= out_cmd;
      cool_side_output          <= 16'h0000;
      feedback_resistance_input <= out_cmd;
    end
  end
endmodule

// File: testbench.sv
// self-checking bench of the fourth-event alarm over its register bus
// assumes event4_pkg, tick_gen, event4_alarm and process_model are compiled first
`timescale 1ns/10ps
module testbench;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, event_out, loop_break_alarm;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] pv_cmd, out_cmd, target_setpoint, integral_time, measured_value;
  logic [15:0] heat_side_output, cool_side_output, feedback_resistance_input;
  logic        autotuning_active, autotune_done, run_mode, rate_limiter_on, remote_mode;
  int          miscompares, comparisons, cycles;
  logic [7:0]  rst_addr [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h24};
  logic [31:0] rst_val  [7] = '{32'h800, 32'h0, 32'h0, 32'h2, 32'hfa0, 32'h0, 32'h0};

  // ----------------------------------------------------------------------
  // clock, partner and design
  // ----------------------------------------------------------------------
  initial hclk = 1'b0;
  always #25 hclk = ~hclk;
  assign hready = hreadyout;
  process_model i_process_model (.hclk(hclk), .hresetn(hresetn), .pv_cmd(pv_cmd), .out_cmd(out_cmd),
    .measured_value(measured_value), .heat_side_output(heat_side_output),
    .cool_side_output(cool_side_output), .feedback_resistance_input(feedback_resistance_input));
  event4_alarm #(.TICK_CYCLES(10)) i_event4_alarm (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .measured_value(measured_value),
    .target_setpoint(target_setpoint), .heat_side_output(heat_side_output),
    .cool_side_output(cool_side_output), .feedback_resistance_input(feedback_resistance_input),
    .out_low_limit(16'h0000), .out_high_limit(16'h03e8), .autotuning_active(autotuning_active),
    .autotune_done(autotune_done), .integral_time(integral_time), .run_mode(run_mode),
    .rate_limiter_on(rate_limiter_on), .remote_mode(remote_mode), .event_out(event_out),
    .loop_break_alarm(loop_break_alarm));

  // ----------------------------------------------------------------------
  // verdict, compares and hang guard
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check32(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check1(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask
  // cycle ceiling well above the whole sequence
  always @(posedge hclk) begin
    cycles++;
    if (cycles >= 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // bus cycles and waits
  // ----------------------------------------------------------------------
  // address phase held until hready, then data phase until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check32(n, e, rd);
    check1("hresp", 1'b0, hresp);
  endtask
  // bounded wait for the alarm (0) or the event output (1)
  task automatic wait_sig(input string n, input bit ev, input logic e, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge hclk);
      if ((ev ? event_out : loop_break_alarm) === e) break;
    end
    check1(n, e, ev ? event_out : loop_break_alarm);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {hsel, hwrite, autotuning_active, autotune_done, run_mode, rate_limiter_on, remote_mode} = '0;
    {haddr, htrans, hwdata, integral_time} = '0;
    hsize = 3'h2;
    pv_cmd = 16'h03e8;
    out_cmd = 16'h0000;
    target_setpoint = 16'h0406;
    hresetn = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 7; i++) rd_chk("reset value", rst_addr[i], rst_val[i]);
    bus(1'b1, 8'h18, 32'h2000);
    rd_chk("delay clamp", 8'h18, 32'h1770);
    bus(1'b1, 8'h18, 32'h0);
    integral_time <= 16'h0003;
    autotune_done <= 1'b1;
    @(posedge hclk);
    autotune_done <= 1'b0;
    integral_time <= 16'h0007;
    repeat (3) @(posedge hclk);
    rd_chk("autotune time", 8'h04, 32'h6);
    // low limit, direct action, value stays put
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b1, 8'h00, 32'ha09);
    run_mode <= 1'b1;
    repeat (80) @(posedge hclk);
    check1("alarm early", 1'b0, loop_break_alarm);
    wait_sig("alarm low limit", 1'b0, 1'b1, 100);
    wait_sig("event out", 1'b1, 1'b1, 5);
    pv_cmd <= 16'h0406;
    wait_sig("alarm clear rise", 1'b0, 1'b0, 10);
    wait_sig("alarm again", 1'b0, 1'b1, 150);
    bus(1'b1, 8'h08, 32'h32);
    wait_sig("alarm clear deadband", 1'b0, 1'b0, 10);
    bus(1'b1, 8'h08, 32'h0);
    out_cmd <= 16'h01f4;
    repeat (200) @(posedge hclk);
    check1("alarm off limit", 1'b0, loop_break_alarm);
    out_cmd <= 16'h0000;
    run_mode <= 1'b0;
    repeat (200) @(posedge hclk);
    check1("alarm stop", 1'b0, loop_break_alarm);
    // high limit, reverse action, value falls the wrong way
    bus(1'b1, 8'h00, 32'ha89);
    out_cmd <= 16'h03e8;
    run_mode <= 1'b1;
    repeat (5) @(posedge hclk);
    pv_cmd <= 16'h03e8;
    wait_sig("alarm high reverse", 1'b0, 1'b1, 150);
    bus(1'b1, 8'h00, 32'hb89);
    wait_sig("alarm heat cool", 1'b0, 1'b0, 10);
    // process high with re-hold and interlock; setpoint change holds the event
    pv_cmd <= 16'h0384;
    bus(1'b1, 8'h14, 32'h3e8);
    bus(1'b1, 8'h00, 32'h865);
    target_setpoint <= 16'h0410;
    pv_cmd <= 16'h03e8;
    repeat (20) @(posedge hclk);
    check1("held event", 1'b0, event_out);
    pv_cmd <= 16'h0384;
    repeat (5) @(posedge hclk);
    pv_cmd <= 16'h03e8;
    wait_sig("event after hold", 1'b1, 1'b1, 10);
    pv_cmd <= 16'h0384;
    repeat (10) @(posedge hclk);
    check1("interlock keeps event", 1'b1, event_out);
    rd_chk("status latched", 8'h1c, 32'h41);
    bus(1'b1, 8'h20, 32'h1);
    wait_sig("interlock clear", 1'b1, 1'b0, 5);
    // remote mode: setpoint change must not re-hold
    remote_mode <= 1'b1;
    target_setpoint <= 16'h041a;
    pv_cmd <= 16'h03e8;
    wait_sig("no rehold in remote", 1'b1, 1'b1, 10);
    end_of_test();
  end
endmodule
